// [rtl/ifc_params.svh]
// Constants of the input data format control block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef IFC_PARAMS_SVH
`define IFC_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define IFC_ADDR_FMT 8'h21
`define IFC_FMT_RST 8'h00
`define IFC_RD_ZERO 8'h00

// ****************************************
// Field positions
// ****************************************
`define IFC_BIT_CODING 7
`define IFC_BW_HI 6
`define IFC_BW_LO 5
`define IFC_BIT_W16 4
`define IFC_BIT_CPLX 3
`define IFC_LAT_HI 2
`define IFC_LAT_LO 0
`define IFC_LCFG_CE 9
`define IFC_LCFG_QM 8

// ****************************************
// Encodings and masks
// ****************************************
`define IFC_BW_4 2'h0
`define IFC_BW_8 2'h1
`define IFC_BW_16 2'h2
`define IFC_BW_32 2'h3
`define IFC_MASK_4 32'h0000000F
`define IFC_MASK_8 32'h000000FF
`define IFC_MASK_16 32'h0000FFFF
`define IFC_MASK_32 32'hFFFFFFFF
`define IFC_SIGN_8 32'h80808080
`define IFC_SIGN_16 32'h80008000
`define IFC_NO_FLIP 32'h00000000
`define IFC_W_BITS_MIN 6'h04
`define IFC_WORD8_BITS 6'h08
`define IFC_WORD16_BITS 6'h10
`define IFC_SHIFT_W8 3
`define IFC_SHIFT_W16 4

`endif

// [rtl/ifc_pkg.sv]
// Types of the input data format control block.
// Assumes the constants header is on the include path.
`include "ifc_params.svh"

package ifc_pkg;

  // ****************************************
  // Link capture states
  // ****************************************
  typedef enum logic [2:0] {
    LS_IDLE = 3'b001,
    LS_WAIT = 3'b010,
    LS_RUN  = 3'b100
  } ifc_link_st_t;

endpackage

// [rtl/ifc_input_format.sv]
// Input data format control register and parallel input capture.
// Assumes data_in and frame_sync are launched on data_clock_out by the source,
// and the configuration port is driven from logic on sys_clk.
//
// Summary of operation
// - Coding bit 7 at 0 means two's complement samples, at 1 straight binary samples, converted here by MSB flip.
// - Bits [6:5] pick 4, 8, 16 or 32 active input lines and the source drives that width.
// - Bit 4 selects 8-bit words when clear and 16-bit words when set toward the datapath.
// - Bit 3 selects real samples at 0 and complex I/Q pairs at 1, supplied by the source.
// - Latency N in bits [2:0] starts sampling at the (N+1)th rising data clock edge after frame sync falls.
// - Quadrature upconvert mode supports only a 32-bit bus with 16-bit words.
`timescale 1ns/10ps
`include "ifc_params.svh"

module ifc_input_format import ifc_pkg::*; #(
  parameter int BUS_W = 32
) (
  // System clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Configuration port
  input wire logic cfg_wr_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic [7:0] cfg_rd_data,
  // Mode and status
  input wire logic quadrature_upconvert_mode,
  output logic cfg_mode_error,
  // Link from the data source
  input wire logic data_clock_out,
  input wire logic frame_sync,
  input wire logic [BUS_W-1:0] data_in,
  // Datapath words
  output logic smp_valid,
  output logic [BUS_W-1:0] smp_data,
  output logic [2:0] smp_words,
  output logic smp_word16,
  output logic smp_complex
);

  // ****************************************
  // Reset synchronisers
  // ****************************************
  logic [1:0] srst_r, lrst_r;
  logic srst_n, lrst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) srst_r <= 2'h0;
    else srst_r <= {srst_r[0], 1'b1};
  end

  always_ff @(posedge data_clock_out or negedge rstn) begin
    if (!rstn) lrst_r <= 2'h0;
    else lrst_r <= {lrst_r[0], 1'b1};
  end

  assign srst_n = srst_r[1];
  assign lrst_n = lrst_r[1];

  // ****************************************
  // Format register
  // ****************************************
  logic [7:0] ctrl_r, ctrl_nxt, rd_r, rd_nxt;
  logic err_r, err_nxt;

  function automatic logic qmode_bad(input logic q, input logic [7:0] c);
    qmode_bad = q && !(c[`IFC_BW_HI:`IFC_BW_LO] == `IFC_BW_32 && c[`IFC_BIT_W16]);
  endfunction

  always_comb begin
    ctrl_nxt = ctrl_r;
    rd_nxt = rd_r;
    err_nxt = err_r;
    if (clk_en) begin
      if (cfg_wr_en && cfg_addr == `IFC_ADDR_FMT) ctrl_nxt = cfg_wr_data;
      rd_nxt = (cfg_addr == `IFC_ADDR_FMT) ? ctrl_r : `IFC_RD_ZERO;
      err_nxt = qmode_bad(quadrature_upconvert_mode, ctrl_r);
    end
  end

  always_ff @(posedge sys_clk or negedge srst_n) begin
    if (!srst_n) begin
      ctrl_r <= `IFC_FMT_RST;
      rd_r <= `IFC_RD_ZERO;
      err_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rd_r <= rd_nxt;
      err_r <= err_nxt;
    end
  end

  assign cfg_rd_data = rd_r;
  assign cfg_mode_error = err_r;

  // ****************************************
  // Configuration crossing into link domain
  // ****************************************
  logic [9:0] cs1_r, cs2_r, cs3_r, lcfg_r, lcfg_nxt;

  always_comb begin
    lcfg_nxt = lcfg_r;
    if (cs2_r == cs3_r) lcfg_nxt = cs3_r;
  end

  always_ff @(posedge data_clock_out or negedge lrst_n) begin
    if (!lrst_n) begin
      cs1_r <= {2'h0, `IFC_FMT_RST};
      cs2_r <= {2'h0, `IFC_FMT_RST};
      cs3_r <= {2'h0, `IFC_FMT_RST};
      lcfg_r <= {2'h0, `IFC_FMT_RST};
    end else begin
      cs1_r <= {clk_en, quadrature_upconvert_mode, ctrl_r};
      cs2_r <= cs1_r;
      cs3_r <= cs2_r;
      lcfg_r <= lcfg_nxt;
    end
  end

  logic lk_ce, lk_q, lk_coding, lk_w16, lk_cx;
  logic [1:0] lk_bw;
  logic [2:0] lk_lat;

  assign lk_ce = lcfg_r[`IFC_LCFG_CE];
  assign lk_q = lcfg_r[`IFC_LCFG_QM];
  assign lk_coding = lcfg_r[`IFC_BIT_CODING];
  assign lk_bw = lk_q ? `IFC_BW_32 : lcfg_r[`IFC_BW_HI:`IFC_BW_LO];
  assign lk_w16 = lk_q | lcfg_r[`IFC_BIT_W16];
  assign lk_cx = lcfg_r[`IFC_BIT_CPLX];
  assign lk_lat = lcfg_r[`IFC_LAT_HI:`IFC_LAT_LO];

  // ****************************************
  // Link capture and word assembly
  // ****************************************
  function automatic logic [31:0] bus_mask(input logic [1:0] bw);
    case (bw)
      `IFC_BW_4: bus_mask = `IFC_MASK_4;
      `IFC_BW_8: bus_mask = `IFC_MASK_8;
      `IFC_BW_16: bus_mask = `IFC_MASK_16;
      default: bus_mask = `IFC_MASK_32;
    endcase
  endfunction

  function automatic logic [31:0] sign_flip(input logic coding, input logic w16);
    if (!coding) sign_flip = `IFC_NO_FLIP;
    else if (w16) sign_flip = `IFC_SIGN_16;
    else sign_flip = `IFC_SIGN_8;
  endfunction

  ifc_link_st_t st_r, st_nxt;
  logic fs_prev_r, fs_prev_nxt, lk_fall, cap, first_cap;
  logic [2:0] cnt_r, cnt_nxt, nw_r, nw_nxt;
  logic [31:0] acc_r, acc_nxt, d_r, d_nxt, raw_r, raw_nxt, acc_cat;
  logic [5:0] fill_r, fill_nxt, w_bits, unit_bits, fill_sum;
  logic v_r, v_nxt, w16o_r, w16o_nxt, cxo_r, cxo_nxt;

  assign lk_fall = fs_prev_r & ~frame_sync;
  assign w_bits = `IFC_W_BITS_MIN << lk_bw;
  assign unit_bits = (lk_w16 ? `IFC_WORD16_BITS : `IFC_WORD8_BITS) << lk_cx;

  always_comb begin
    st_nxt = st_r;
    fs_prev_nxt = fs_prev_r;
    cnt_nxt = cnt_r;
    acc_nxt = acc_r;
    fill_nxt = fill_r;
    v_nxt = v_r;
    d_nxt = d_r;
    raw_nxt = raw_r;
    nw_nxt = nw_r;
    w16o_nxt = w16o_r;
    cxo_nxt = cxo_r;
    cap = 1'b0;
    first_cap = 1'b0;
    fill_sum = fill_r;
    acc_cat = acc_r;
    if (lk_ce) begin
      fs_prev_nxt = frame_sync;
      v_nxt = 1'b0;
      case (st_r)
        LS_IDLE: begin
          if (lk_fall) begin
            cnt_nxt = 3'h1;
            acc_nxt = 32'h0;
            fill_nxt = 6'h0;
            if (lk_lat == 3'h0) begin
              first_cap = 1'b1;
              st_nxt = LS_RUN;
            end else begin
              st_nxt = LS_WAIT;
            end
          end
        end
        LS_WAIT: begin
          if (frame_sync) st_nxt = LS_IDLE;
          else if (cnt_r == lk_lat) begin
            first_cap = 1'b1;
            st_nxt = LS_RUN;
          end else cnt_nxt = cnt_r + 3'h1;
        end
        LS_RUN: begin
          if (frame_sync) st_nxt = LS_IDLE;
          else cap = 1'b1;
        end
        default: st_nxt = LS_IDLE;
      endcase
      if (cap || first_cap) begin
        acc_cat = (first_cap ? 32'h0 : acc_r) | ((data_in & bus_mask(lk_bw)) << (first_cap ? 6'h0 : fill_r));
        fill_sum = (first_cap ? 6'h0 : fill_r) + w_bits;
        if (fill_sum >= unit_bits) begin
          v_nxt = 1'b1;
          raw_nxt = acc_cat;
          d_nxt = acc_cat ^ sign_flip(lk_coding, lk_w16);
          nw_nxt = 3'(fill_sum >> (lk_w16 ? `IFC_SHIFT_W16 : `IFC_SHIFT_W8));
          w16o_nxt = lk_w16;
          cxo_nxt = lk_cx;
          acc_nxt = 32'h0;
          fill_nxt = 6'h0;
        end else begin
          acc_nxt = acc_cat;
          fill_nxt = fill_sum;
        end
      end
    end
  end

  always_ff @(posedge data_clock_out or negedge lrst_n) begin
    if (!lrst_n) begin
      st_r <= LS_IDLE;
      fs_prev_r <= 1'b1;
      cnt_r <= 3'h0;
      acc_r <= 32'h0;
      fill_r <= 6'h0;
      v_r <= 1'b0;
      d_r <= 32'h0;
      raw_r <= 32'h0;
      nw_r <= 3'h0;
      w16o_r <= 1'b0;
      cxo_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fs_prev_r <= fs_prev_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
      fill_r <= fill_nxt;
      v_r <= v_nxt;
      d_r <= d_nxt;
      raw_r <= raw_nxt;
      nw_r <= nw_nxt;
      w16o_r <= w16o_nxt;
      cxo_r <= cxo_nxt;
    end
  end

  assign smp_valid = v_r;
  assign smp_data = d_r;
  assign smp_words = nw_r;
  assign smp_word16 = w16o_r;
  assign smp_complex = cxo_r;

  // ****************************************
  // Assertions
  // ****************************************
  coding_flip_a: assert property (@(posedge data_clock_out) disable iff (!lrst_n)
    $rose(v_r) && lk_coding == $past(lk_coding) |-> (d_r ^ raw_r) == sign_flip(lk_coding, w16o_r))
    else $error("sample coding conversion wrong");
  bus_width_a: assert property (@(posedge data_clock_out) disable iff (!lrst_n)
    v_r && $stable(lcfg_r) && lk_bw == `IFC_BW_32 |-> nw_r == (w16o_r ? 3'h2 : 3'h4))
    else $error("word count wrong for full bus");
  word_width_a: assert property (@(posedge data_clock_out) disable iff (!lrst_n)
    v_r && $stable(lcfg_r) |-> w16o_r == lk_w16)
    else $error("word width flag disagrees with field");
  complex_pairs_a: assert property (@(posedge data_clock_out) disable iff (!lrst_n)
    v_r && cxo_r |-> nw_r[0] == 1'b0)
    else $error("complex output not in I/Q pairs");
  latency_two_a: assert property (@(posedge data_clock_out) disable iff (!lrst_n)
    (lk_ce && st_r == LS_IDLE && lk_fall && lk_lat == 3'h2) ##1 (lk_ce && !frame_sync)[*2]
      |=> st_r == LS_RUN && $past(st_r) == LS_WAIT)
    else $error("sampling did not start on third edge");
  qmode_error_a: assert property (@(posedge sys_clk) disable iff (!srst_n)
    clk_en && qmode_bad(quadrature_upconvert_mode, ctrl_r) |=> cfg_mode_error)
    else $error("unsupported quadrature format not flagged");
  readback_a: assert property (@(posedge sys_clk) disable iff (!srst_n)
    clk_en && cfg_wr_en && cfg_addr == `IFC_ADDR_FMT ##1 clk_en && !cfg_wr_en && cfg_addr == `IFC_ADDR_FMT
      |=> cfg_rd_data == $past(cfg_wr_data, 2))
    else $error("format register readback mismatch");

  real_cov_c: cover property (@(posedge data_clock_out) disable iff (!lrst_n) v_r && !cxo_r);
  complex_cov_c: cover property (@(posedge data_clock_out) disable iff (!lrst_n) v_r && cxo_r && w16o_r);
  nibble_cov_c: cover property (@(posedge data_clock_out) disable iff (!lrst_n) v_r && lk_bw == `IFC_BW_4);
  late_cov_c: cover property (@(posedge data_clock_out) disable iff (!lrst_n) first_cap && lk_lat == 3'h7);

endmodule

// [sim/ifc_source_model.sv]
// Behavioural data source on the far side of the parallel input port.
// Assumes the link clock is made by the bench and runs free.
`timescale 1ns/10ps

module ifc_source_model (
  // Link clock
  input wire logic data_clock_out,
  // Frame and data toward the device
  output logic frame_sync,
  output logic [31:0] data_in
);
  initial begin
    frame_sync = 1'b1;
    data_in = 32'h5A5A5A5A;
  end

  // Sends n samples counting up from base while frame sync is low
  task automatic send_frame(input logic [31:0] base, input int n);
    @(posedge data_clock_out);
    #1;
    frame_sync = 1'b0;
    data_in = base;
    for (int i = 1; i < n; i++) begin
      @(posedge data_clock_out);
      #1;
      data_in = base + i;
    end
    @(posedge data_clock_out);
    #1;
    frame_sync = 1'b1;
    data_in = ~data_in;
  endtask
endmodule

// [sim/input_data_format_control_bench.sv]
// Self-checking bench for the input format register and capture path.
// Assumes the design package, header and source model are compiled first.
`timescale 1ns/10ps
`include "ifc_params.svh"

module input_data_format_control_bench import ifc_pkg::*;;
  logic sys_clk = 1'b0;
  logic data_clock_out = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic cfg_wr_en = 1'b0;
  logic [7:0] cfg_addr = 8'h21;
  logic [7:0] cfg_wr_data = 8'h00;
  logic [7:0] cfg_rd_data;
  logic qmode = 1'b0;
  logic cfg_mode_error;
  logic frame_sync;
  logic [31:0] data_in;
  logic smp_valid;
  logic [31:0] smp_data;
  logic [2:0] smp_words;
  logic smp_word16;
  logic smp_complex;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  always #25 sys_clk = ~sys_clk;
  initial begin
    #3.7;
    forever #6 data_clock_out = ~data_clock_out;
  end

  ifc_input_format dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .cfg_wr_en(cfg_wr_en),
    .cfg_addr(cfg_addr), .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
    .quadrature_upconvert_mode(qmode), .cfg_mode_error(cfg_mode_error),
    .data_clock_out(data_clock_out), .frame_sync(frame_sync), .data_in(data_in),
    .smp_valid(smp_valid), .smp_data(smp_data), .smp_words(smp_words),
    .smp_word16(smp_word16), .smp_complex(smp_complex));
  ifc_source_model src (.data_clock_out(data_clock_out), .frame_sync(frame_sync), .data_in(data_in));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] val);
    @(posedge sys_clk);
    #1;
    cfg_wr_en = 1'b1;
    cfg_addr = addr;
    cfg_wr_data = val;
    @(posedge sys_clk);
    #1;
    cfg_wr_en = 1'b0;
    cfg_addr = `IFC_ADDR_FMT;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_regs();
    chk("fmt_reset", {24'h0, cfg_rd_data}, 32'h0);
    reg_write(`IFC_ADDR_FMT, 8'hA5);
    chk("fmt_rw", {24'h0, cfg_rd_data}, 32'hA5);
    reg_write(8'h22, 8'h3C);
    chk("fmt_kept", {24'h0, cfg_rd_data}, 32'hA5);
    clk_en = 1'b0;
    reg_write(`IFC_ADDR_FMT, 8'h5A);
    clk_en = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("fmt_frozen", {24'h0, cfg_rd_data}, 32'hA5);
    @(posedge sys_clk);
    #1;
    cfg_addr = 8'h20;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("unmapped_rd", {24'h0, cfg_rd_data}, 32'h0);
    cfg_addr = `IFC_ADDR_FMT;
    $display("test regs done");
  endtask

  task automatic run_frame(input logic [7:0] fmt, input logic [31:0] base, input logic [31:0] exp,
    input logic [31:0] mask, input logic [2:0] words, input logic w16, input logic cplx);
    logic [31:0] g_data;
    logic [4:0] g_flags;
    reg_write(`IFC_ADDR_FMT, fmt);
    chk("fmt_rd", {24'h0, cfg_rd_data}, {24'h0, fmt});
    g_flags = 5'h00;
    g_data = 32'h0;
    fork
      src.send_frame(base, 9);
      for (int k = 0; k < 20 && g_flags[0] !== 1'b1; k++) begin
        @(posedge data_clock_out);
        #2;
        g_flags = {smp_words[0], smp_word16, smp_complex, 1'b0, smp_valid};
        g_data = smp_data;
        if (smp_valid === 1'b1) begin
          chk("smp_words", {29'h0, smp_words}, {29'h0, words});
        end
      end
    join
    chk("smp_valid", {31'h0, g_flags[0]}, 32'h1);
    chk("smp_data", g_data & mask, exp);
    chk("smp_w16", {31'h0, g_flags[3]}, {31'h0, w16});
    chk("smp_cplx", {31'h0, g_flags[2]}, {31'h0, cplx});
    $display("test frame %h done", fmt);
  endtask

  task automatic test_mode();
    @(posedge sys_clk);
    #1;
    qmode = 1'b1;
    run_frame(8'h28, 32'h11223344, 32'h11223344, 32'hFFFFFFFF, 3'h2, 1'b1, 1'b1);
    chk("mode_err_set", {31'h0, cfg_mode_error}, 32'h1);
    reg_write(`IFC_ADDR_FMT, 8'h70);
    chk("mode_err_clr", {31'h0, cfg_mode_error}, 32'h0);
    qmode = 1'b0;
    $display("test mode done");
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    repeat (8) @(posedge sys_clk);
    #1;
    test_regs();
    run_frame(8'h70, 32'hA1B2C3D4, 32'hA1B2C3D4, 32'hFFFFFFFF, 3'h2, 1'b1, 1'b0);
    run_frame(8'hE0, 32'h12345678, 32'h92B4D6F8, 32'hFFFFFFFF, 3'h4, 1'b0, 1'b0);
    run_frame(8'h73, 32'h00010000, 32'h00010003, 32'hFFFFFFFF, 3'h2, 1'b1, 1'b0);
    run_frame(8'h72, 32'h00020000, 32'h00020002, 32'hFFFFFFFF, 3'h2, 1'b1, 1'b0);
    run_frame(8'h77, 32'h00070000, 32'h00070007, 32'hFFFFFFFF, 3'h2, 1'b1, 1'b0);
    run_frame(8'h28, 32'hAB000011, 32'h00001211, 32'h0000FFFF, 3'h2, 1'b0, 1'b1);
    run_frame(8'h00, 32'hFFFFFF05, 32'h00000065, 32'h000000FF, 3'h1, 1'b0, 1'b0);
    run_frame(8'h50, 32'hCCCC1234, 32'h00001234, 32'h0000FFFF, 3'h1, 1'b1, 1'b0);
    test_mode();
    print_verdict();
  end
endmodule
